/* File: rtl/sdct_consts.vh */
`ifndef SDCT_CONSTS_VH
`define SDCT_CONSTS_VH
// Command encodings on the command bus {ras_n,cas_n,we_n}, chip select low
`define SDCT_CMD_MRS        3'h0
`define SDCT_CMD_REF        3'h1
`define SDCT_CMD_PRE        3'h2
`define SDCT_CMD_ACT        3'h3
`define SDCT_CMD_WR         3'h4
`define SDCT_CMD_ZQ         3'h6
`define SDCT_CMD_RD         3'h5
`define SDCT_CMD_NOP        3'h7
// Address bits that qualify commands
`define SDCT_A_AP           10
`define SDCT_A_BC           12
// Mode register zero fields
`define SDCT_MR0_BL_LSB     0
`define SDCT_MR0_BL_FIXED4  2'h2
`define SDCT_MR0_BL_OTF     2'h1
`define SDCT_MR0_WR_LSB     9
// Internal write start offsets after write latency, in link cycles
`define SDCT_WSTART_LONG    4'h4
`define SDCT_WSTART_FIXED4  4'h2
// Short calibration length, link cycles
`define SDCT_ZQ_CYCLES      7'h40
// Busy times of background operations, link cycles
`define SDCT_ACT_BUSY       6'h0a
`define SDCT_PRE_BUSY       6'h0a
`define SDCT_REF_BUSY       6'h20
// Asynchronous termination delay window in ns
`define SDCT_AODT_MIN_NS    2
`define SDCT_AODT_MAX_NS    8
`endif

/* File: rtl/sdct_link_edge.v */
`timescale 1ns/1ps
// Samples the link clock and pins into CLK, marks each link rising edge
module sdct_link_edge #(
   parameter W = 8
) (
   input  wire         clk,
   input  wire         nrst,
   input  wire         link_ck,
   input  wire [W-1:0] pins,
   output reg          rise,
   output reg  [W-1:0] pins_q
);
   reg         ck_s1_reg;
   reg         ck_s2_reg;
   reg         ck_s3_reg;
   reg [W-1:0] p_s1_reg;
   reg [W-1:0] p_s2_reg;

   // Two-flop synchronisers; the edge test reads only the second and third stage
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ck_s1_reg <= 1'b0;
         ck_s2_reg <= 1'b0;
         ck_s3_reg <= 1'b0;
         p_s1_reg  <= {W{1'b0}};
         p_s2_reg  <= {W{1'b0}};
         rise      <= 1'b0;
         pins_q    <= {W{1'b0}};
      end else begin
         ck_s1_reg <= link_ck;
         ck_s2_reg <= ck_s1_reg;
         ck_s3_reg <= ck_s2_reg;
         p_s1_reg  <= pins;
         p_s2_reg  <= p_s1_reg;
         rise      <= ck_s2_reg & ~ck_s3_reg;
         // Pins are latched on the link edge itself, as the device would
         if (ck_s2_reg & ~ck_s3_reg)
            pins_q <= p_s2_reg;
      end
   end
endmodule

/* File: rtl/sdct_timing.v */
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Count cycles in real link clock edges.
// RL2: Mode set spacing four cycles, controller's duty.
// RL3: Illegal timing needs reset and reinitialisation.
// RL4: Write recovery taken from mode register zero.
// RL5: Nanosecond limits become rounded-up cycle counts; AON_MAX0 rounds the termination max delay down.
// RL6: Controller rounds write recovery up for powerdown.
// RL7: Internal write starts WL+4, or WL+2 fixed chop.
// RL8: Powerdown waits for ongoing background operations.
// RL9: Controller honours refresh to powerdown spacing.
// RL10: Termination high time measurement points, controller.
// RL11: Short calibration completes within 64 cycles.
// RL12: Locked loop needed by read and sync termination.
// RL13: At most eight postponed refreshes, controller.
// RL14: Clock may run slowly, refresh interval kept.
// RL15: Controller spaces register read end and mode set.
// RL16: Asynchronous termination delays apply in frozen powerdown.
// RL17: Termination held high four or six cycles.
// RL18: Slow exit waits max of 10 cycles, 24 ns.
// RL19: Any exit waits max of 3 cycles, 6 ns.
// RL20: Controller uses per-constraint cycle counters.
// RL21: Controller forces refresh before postponement limit.
`include "sdct_consts.vh"
module sdct_timing #(
   parameter CLK_NS = 10,
   parameter WL     = 5
) (
   input  wire        CLK,
   input  wire        NRST,
   input  wire        LINK_CK,
   input  wire        CKE,
   input  wire        CS_N,
   input  wire [2:0]  CMD,
   input  wire        ODT,
   input  wire        A_AP,
   input  wire        A_BC,
   input  wire [3:0]  MR_WR,
   input  wire [1:0]  MR_BL,
   input  wire        DLL_FROZEN,
   output reg         WRITE_START,
   output reg         WRITE_CHOP,
   output reg  [3:0]  WRITE_RECOVERY,
   output reg         CAL_BUSY,
   output reg         CAL_DONE,
   output reg         BG_BUSY,
   output reg         LOW_POWER,
   output reg         TERM_ON
);
   // Asynchronous termination delays in CLK cycles: min rounds up, max down
   localparam [3:0] AON_MIN = (`SDCT_AODT_MIN_NS + CLK_NS - 1) / CLK_NS; // RL5
   localparam [3:0] AON_MAX0 = `SDCT_AODT_MAX_NS / CLK_NS;
   localparam [3:0] AON_DLY = (AON_MAX0 < AON_MIN) ? AON_MIN : AON_MAX0;
   localparam WQ = WL + `SDCT_WSTART_LONG;
   localparam S_RUN  = 3'h1;
   localparam S_WAIT = 3'h2;
   localparam S_PD   = 3'h4;

   wire        rise;
   wire [8:0]  pq;
   reg  [2:0]  st_reg;
   reg  [2:0]  st_next;
   reg  [WQ:0] wq_reg;
   reg  [WQ:0] wc_reg;
   reg  [6:0]  zq_cnt_reg;
   reg  [5:0]  bg_cnt_reg;
   reg  [5:0]  bg_cnt_next;
   reg  [3:0]  aon_cnt_reg;
   reg         odt_t_reg;

   sdct_link_edge #(.W(9)) u_edge (
      .clk    (CLK),
      .nrst   (NRST),
      .link_ck(LINK_CK),
      .pins   ({CKE, CS_N, CMD, ODT, A_AP, A_BC, 1'b0}),
      .rise   (rise),
      .pins_q (pq)
   );

   wire       cke_q = pq[8];
   wire       cmd_v = ~pq[7];
   wire [2:0] cmd_q = pq[6:4];
   wire       odt_q = pq[3];
   wire       bc_q  = pq[1];

   // Command decode used by several processes
   function is_cmd;
      input       v;
      input [2:0] c;
      input [2:0] k;
      begin
         is_cmd = v & (c == k);
      end
   endfunction

   wire wr_cmd = is_cmd(cmd_v, cmd_q, `SDCT_CMD_WR);
   wire fixed4 = (MR_BL == `SDCT_MR0_BL_FIXED4);
   wire chop   = fixed4 | ((MR_BL == `SDCT_MR0_BL_OTF) & ~bc_q);
   wire pd_req = ~cke_q & ~LOW_POWER;

   // Write pipeline shifts once per real link edge, never per averaged time
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         wq_reg         <= {(WQ+1){1'b0}};
         wc_reg         <= {(WQ+1){1'b0}};
         WRITE_START    <= 1'b0;
         WRITE_CHOP     <= 1'b0;
         WRITE_RECOVERY <= 4'h0;
      end else begin
         WRITE_START <= 1'b0;
         if (rise) begin // RL1
            wq_reg <= {wq_reg[WQ-1:0], wr_cmd};
            wc_reg <= {wc_reg[WQ-1:0], chop};
            // Fixed chop starts two cycles earlier than long bursts
            if (fixed4 ? wq_reg[WL+`SDCT_WSTART_FIXED4-1] : wq_reg[WQ-1]) begin // RL7
               WRITE_START    <= 1'b1;
               WRITE_CHOP     <= fixed4 ? 1'b1 : wc_reg[WQ-1];
               WRITE_RECOVERY <= MR_WR; // RL4
            end
         end
      end
   end

   // Short calibration: busy for 63 link cycles, one under the documented cycle budget
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         zq_cnt_reg <= 7'h00;
         CAL_BUSY   <= 1'b0;
         CAL_DONE   <= 1'b0;
      end else begin
         CAL_DONE <= 1'b0;
         if (rise) begin
            if (is_cmd(cmd_v, cmd_q, `SDCT_CMD_ZQ) && !CAL_BUSY) begin
               zq_cnt_reg <= `SDCT_ZQ_CYCLES - 7'h01;
               CAL_BUSY   <= 1'b1;
            end else if (CAL_BUSY) begin
               zq_cnt_reg <= zq_cnt_reg - 7'h01;
               if (zq_cnt_reg == 7'h01) begin // RL11
                  CAL_BUSY <= 1'b0;
                  CAL_DONE <= 1'b1;
               end
            end
         end
      end
   end

   // Next background count; busy must show at the command's own edge
   always @* begin
      bg_cnt_next = bg_cnt_reg;
      if (is_cmd(cmd_v, cmd_q, `SDCT_CMD_REF))
         bg_cnt_next = `SDCT_REF_BUSY;
      else if (is_cmd(cmd_v, cmd_q, `SDCT_CMD_ACT))
         bg_cnt_next = `SDCT_ACT_BUSY;
      else if (is_cmd(cmd_v, cmd_q, `SDCT_CMD_PRE) || (wr_cmd && pq[2]))
         bg_cnt_next = `SDCT_PRE_BUSY;
      else if (bg_cnt_reg != 6'h00)
         bg_cnt_next = bg_cnt_reg - 6'h01;
   end

   // Background operations keep running after CKE drops; a lagging busy
   // flag would let power-down slip in one link cycle after a command
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         bg_cnt_reg <= 6'h00;
         BG_BUSY    <= 1'b0;
      end else if (rise) begin
         bg_cnt_reg <= bg_cnt_next;
         BG_BUSY    <= (bg_cnt_next != 6'h00); // RL8
      end
   end

   // Power state: low CKE waits for background work before taking effect
   always @* begin
      st_next = st_reg;
      case (st_reg)
         S_RUN:  if (rise && pd_req) st_next = BG_BUSY ? S_WAIT : S_PD;
         S_WAIT: if (rise && cke_q) st_next = S_RUN;
                 else if (!BG_BUSY) st_next = S_PD; // RL8
         S_PD:   if (rise && cke_q) st_next = S_RUN;
         default: st_next = S_RUN;
      endcase
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         st_reg    <= S_RUN;
         LOW_POWER <= 1'b0;
      end else begin
         st_reg    <= st_next;
         LOW_POWER <= (st_next == S_PD);
      end
   end

   // Termination: synchronous in normal mode, fixed async delay in frozen powerdown
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         odt_t_reg   <= 1'b0;
         aon_cnt_reg <= 4'h0;
         TERM_ON     <= 1'b0;
      end else if (LOW_POWER && DLL_FROZEN) begin
         odt_t_reg <= odt_q;
         if (odt_q != odt_t_reg)
            aon_cnt_reg <= AON_DLY; // RL16
         else if (aon_cnt_reg != 4'h0)
            aon_cnt_reg <= aon_cnt_reg - 4'h1;
         if (aon_cnt_reg == 4'h1)
            TERM_ON <= odt_t_reg; // RL16
      end else begin
         odt_t_reg   <= odt_q;
         aon_cnt_reg <= 4'h0;
         if (rise)
            TERM_ON <= odt_q;
      end
   end
endmodule

/* File: tb/sdct_ctrl_model.sv */
`timescale 1ns/1ps
// Controller model: free memory clock, one command per call
module sdct_ctrl_model (
   output reg       LK, CKE, CS_N, ODT, A_AP, A_BC,
   output reg [2:0] CMD
);
   // Memory clock runs free; every counted cycle is a real edge
   initial begin
      {LK, CKE, CS_N, ODT, A_AP, A_BC, CMD} = 9'h0c7;
      forever #62.5 LK = ~LK;
   end
   // Pins change at the falling edge, stable around the rising edge.
   // Calls come far apart and use no refresh, read or register read,
   // so every spacing limit is met
   task issue(input [2:0] c, input bc);
      begin
         @(negedge LK) {CS_N, CMD, A_BC} = {1'b0, c, bc};
         @(negedge LK) {CS_N, CMD, A_BC} = {1'b1, 3'h7, ~bc};
      end
   endtask
endmodule

/* File: tb/sdct_monitor.sv */
`timescale 1ns/1ps
// Watches the write, calibration and power-down outputs of the timing block
module sdct_monitor (
   input wire       CLK, NRST, LINK_CK, CKE, WRITE_START, WRITE_CHOP,
   input wire       CAL_BUSY, CAL_DONE, BG_BUSY, LOW_POWER,
   input wire [1:0] MR_BL,
   input wire [3:0] MR_WR, WRITE_RECOVERY
);
   reg [9:0] bcnt_reg;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // Busy length in CLK: 64 link cycles of 12.5 CLK plus sync slack
   always @(posedge CLK or negedge NRST)
      if (!NRST) bcnt_reg <= 10'h0;
      else bcnt_reg <= CAL_BUSY ? bcnt_reg + 10'h1 : 10'h0;
   property p_ws_pulse; WRITE_START |=> !WRITE_START; endproperty
   a_ws_pulse: assert property (p_ws_pulse) else $error("start too long");
   property p_ws_fix4; WRITE_START && MR_BL == 2'h2 |-> WRITE_CHOP; endproperty
   a_ws_fix4: assert property (p_ws_fix4) else $error("chop missing");
   property p_ws_bl8; WRITE_START && MR_BL == 2'h0 |-> !WRITE_CHOP; endproperty
   a_ws_bl8: assert property (p_ws_bl8) else $error("chop on fixed 8");
   property p_wr_rec; WRITE_START |-> WRITE_RECOVERY == MR_WR; endproperty
   a_wr_rec: assert property (p_wr_rec) else $error("recovery wrong");
   property p_cd_pulse; CAL_DONE |=> !CAL_DONE; endproperty
   a_cd_pulse: assert property (p_cd_pulse) else $error("done too long");
   property p_cal_len; bcnt_reg < 10'h348; endproperty
   a_cal_len: assert property (p_cal_len) else $error("calibration slow");
   property p_lp_idle; LOW_POWER |-> !BG_BUSY; endproperty
   a_lp_idle: assert property (p_lp_idle) else $error("low power while busy");
   property p_lp_cke; $rose(LOW_POWER) |-> !CKE; endproperty
   a_lp_cke: assert property (p_lp_cke) else $error("low power with CKE high");
   c_chop: cover property (WRITE_START && WRITE_CHOP);
   c_cal: cover property (CAL_DONE);
   c_lp: cover property ($rose(LOW_POWER));
endmodule
bind sdct_timing sdct_monitor u_mon (.*);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "sdct_consts.vh"
module tb_top;
   localparam WL = 5;
   reg        CLK = 1'b0, NRST = 1'b0, DLL_FROZEN = 1'b0;
   reg  [3:0] MR_WR = 4'h6;
   reg  [1:0] MR_BL = 2'h0;
   wire       LK, CKE, CS_N, ODT, A_AP, A_BC, WS, WC, CB, CD, BB, LP, TO;
   wire [2:0] CMD;
   wire [3:0] REC;
   integer    mismatches = 0, n_compared = 0, cyc = 0, lkcnt = 0, k, s;
   sdct_ctrl_model mdl (.LK(LK), .CKE(CKE), .CS_N(CS_N), .ODT(ODT), .A_AP(A_AP),
      .A_BC(A_BC), .CMD(CMD));
   sdct_timing #(.WL(WL)) uut (.CLK(CLK), .NRST(NRST), .LINK_CK(LK), .CKE(CKE),
      .CS_N(CS_N), .CMD(CMD), .ODT(ODT), .A_AP(A_AP), .A_BC(A_BC), .MR_WR(MR_WR),
      .MR_BL(MR_BL), .DLL_FROZEN(DLL_FROZEN), .WRITE_START(WS), .WRITE_CHOP(WC),
      .WRITE_RECOVERY(REC), .CAL_BUSY(CB), .CAL_DONE(CD), .BG_BUSY(BB),
      .LOW_POWER(LP), .TERM_ON(TO));
   initial forever #5 CLK = ~CLK;
   always @(posedge LK) lkcnt = lkcnt + 1;
   // Hang guard, well above the fewer than two thousand cycles the run needs
   always @(posedge CLK) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         mismatches = mismatches + 1;
         print_verdict;
      end
   end
   task chk(input [7:0] g, e);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // Link edges from write to internal start, chop flag, recovery copy
   task t_write(input [1:0] bl, input bc, ce, input [7:0] d);
      begin
         @(posedge CLK) #1 {MR_BL, MR_WR} = {bl, MR_WR + 4'h1};
         mdl.issue(`SDCT_CMD_WR, bc);
         s = lkcnt;
         for (k = 0; k < 3000 && WS !== 1'b1; k = k + 1) @(posedge CLK) #1;
         chk(8'(lkcnt - s), d);
         chk(WC, ce);
         chk(REC, MR_WR);
      end
   endtask
   task t_zq;
      begin
         mdl.issue(`SDCT_CMD_ZQ, 1'b0);
         s = lkcnt;
         chk(CB, 1'b1);
         for (k = 0; k < 3000 && CD !== 1'b1; k = k + 1) @(posedge CLK) #1;
         chk(CD, 1'b1);
         chk(lkcnt - s <= 64, 1'b1);
         chk(CB, 1'b0);
      end
   endtask
   // Power-down asked during activate takes hold only once it ends
   task t_pd;
      begin
         mdl.issue(`SDCT_CMD_ACT, 1'b0);
         mdl.CKE = 1'b0;
         repeat (30) @(posedge CLK);
         #1 chk({BB, LP}, 8'h2);
         for (k = 0; k < 3000 && LP !== 1'b1; k = k + 1) @(posedge CLK) #1;
         chk({BB, LP}, 8'h1);
         {DLL_FROZEN, mdl.ODT} = 2'h3;
         // ODT is taken at the next link edge, up to one link period away
         repeat (20) @(posedge CLK);
         #1 chk(TO, 1'b1);
         {DLL_FROZEN, mdl.ODT, mdl.CKE} = 3'h1;
      end
   endtask
   task print_verdict;
      begin
         if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      repeat (2) @(posedge CLK);
      #1 NRST = 1'b1;
      repeat (10) @(posedge CLK);
      t_write(2'h0, 1'b1, 1'b0, WL + 4);
      t_write(2'h1, 1'b1, 1'b0, WL + 4);
      t_write(2'h1, 1'b0, 1'b1, WL + 4);
      t_write(2'h2, 1'b1, 1'b1, WL + 2);
      t_zq;
      t_pd;
      print_verdict;
   end
endmodule
